// ==== rtl/pmt_map.svh ====
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH
// Register offsets (word index on the register port)
`define PMT_OFF_CTRL 8'h00
`define PMT_OFF_MAIN_PER 8'h01
`define PMT_OFF_MAIN_CMP0 8'h02
`define PMT_OFF_SEC_PER 8'h05
`define PMT_OFF_SEC_CMP_SH 8'h06
`define PMT_OFF_SEC_CMP 8'h07
`define PMT_OFF_CHAN 8'h08
`define PMT_OFF_MOD 8'h09
`define PMT_OFF_SEC_OUT 8'h0A
`define PMT_OFF_PATTERN 8'h0B
`define PMT_OFF_TRAP 8'h0C
`define PMT_OFF_STATUS 8'h0D
`define PMT_OFF_COUNT 8'h0E
// Control register fields
`define PMT_CTRL_MAIN_RUN 0
`define PMT_CTRL_MAIN_SS 1
`define PMT_CTRL_MAIN_CENTER 2
`define PMT_CTRL_MAIN_STE 3
`define PMT_CTRL_SEC_RUN 4
`define PMT_CTRL_SEC_SS 5
`define PMT_CTRL_SEC_STE 6
`define PMT_CTRL_TRIG_EV 8
`define PMT_CTRL_TRIG_DIR 12
// Channel, modulation and second-output fields
`define PMT_CHAN_MODE 0
`define PMT_CHAN_OUT_SEL 16
`define PMT_MOD_MAIN_EN 0
`define PMT_MOD_SEC_EN 8
`define PMT_MOD_PSL 16
`define PMT_SOUT_PS 0
`define PMT_SOUT_IM 1
`define PMT_SOUT_PSL 2
`define PMT_SOUT_OE 3
// Pattern register fields
`define PMT_PAT_SHADOW 0
`define PMT_PAT_ACTIVE 8
`define PMT_PAT_REQ 16
`define PMT_PAT_REM 17
`define PMT_PAT_SW_SEL 18
`define PMT_PAT_SW_SYN 22
`define PMT_PAT_EN 24
// Trap register fields
`define PMT_TRAP_PEN 0
`define PMT_TRAP_M2 1
`define PMT_TRAP_SYNC 2
`define PMT_TRAP_OE 4
`define PMT_TRAP_FLAG 16
`define PMT_TRAP_STATE 17
// Codes
`define PMT_MODE_HYST 4'h9
`define PMT_SW_MAIN_PM 3'h1
`define PMT_SW_MAIN_OM 3'h2
`define PMT_SW_SEC_PM 3'h3
`define PMT_SW_CH1_CM 3'h4
`define PMT_SW_HALL 3'h5
`define PMT_SYN_DIRECT 2'h0
`define PMT_SYN_MAIN_ZM 2'h1
`define PMT_SYN_SEC_ZM 2'h2
`define PMT_TSYN_NONE 2'h0
`define PMT_TSYN_MAIN 2'h1
`define PMT_TSYN_SEC 2'h2
`define PMT_TRIG_PM 3'h3
`define PMT_TRIG_ZM 3'h4
`define PMT_TRIG_OM 3'h5
`define PMT_DIR_ANY 2'h0
`define PMT_DIR_UP 2'h1
`define PMT_DIR_DOWN 2'h2
// Reset values
`define PMT_RST_CNT 16'h0000
`define PMT_RST_WORD 32'h0000_0000
`endif

// ==== rtl/pmt_pkg.sv ====
package pmt_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pmt_bus_t;

   typedef struct packed {
      logic [15:0] main_cnt;
      logic main_dn, main_run, main_ss, main_center, main_ste;
      logic [15:0] main_per, main_per_sh;
      logic [2:0][15:0] main_cmp, main_cmp_sh;
      logic [2:0] ch_state;
      logic [2:0][3:0] ch_mode;
      logic [5:0] main_en, sec_en, out_sel, passive_level_field;
      logic [15:0] sec_cnt;
      logic sec_run, sec_ss, sec_ste;
      logic [15:0] sec_per, sec_per_sh, sec_cmp, sec_cmp_sh;
      logic sec_state, sec_ps, sec_ps_sh, sec_im, sec_im_sh, sec_psl, sec_psl_sh, sec_oe;
      logic [2:0] trig_ev;
      logic [1:0] trig_dir;
      logic [5:0] pat, pat_sh;
      logic rem, pat_en;
      logic [2:0] sw_sel;
      logic [1:0] sw_syn;
      logic trap_pen, trap_m2;
      logic [1:0] trap_sync;
      logic [6:0] trap_oe;
      logic trap_flag, trap_state;
      logic [5:0] pwm;
      logic pin;
      logic [31:0] rdata;
   } pmt_state_t;
endpackage

// ==== rtl/pmt_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmt_map.svh"
// Operation
// - Single-shot end of main period stops main timer and clears all channel states.
// - Hysteresis mode clears channel compare state while its position input is low.
// - Hysteresis mode with position low drives both channel outputs passive.
// - Hysteresis mode sets channel compare state only while position input is high.
// - Second timer has one compare channel and counts up, edge-aligned style.
// - Second shadow transfer copies compare shadow to active; software writes shadow only.
// - Second passive select, invert and passive level are shadowed, read as active.
// - Second compare set and zero clear act only while second timer runs.
// - Separate active-state selects for internal modulation and second output pin.
// - Selected main timer event sets second timer run bit.
// - Pattern mode lets an output be active only where its pattern bit is one.
// - Selected switching event sets reminder flag outside direct mode; pattern transfer clears it.
// - Pending reminder transfers pattern at sync event, or immediately in direct mode.
// - Pattern write with transfer request sets the reminder flag, except in direct mode.
// - Request events: main period up, one down, second period, ch1 compare, hall.
// - Sync events: main zero-match counting up, second zero-match.
// - Enabled active trap input enters trap state at once, forcing selected outputs passive.
// - Software setting trap input flag also enters trap state.
// - Trap flag clears by itself when input inactive, or by software in mode 2.
// - Trap state leaves at selected event: main, second period, or unsynchronised.
// - Output drives passive level when inactive and its inverse when active.
// - All seven outputs are registered on the peripheral clock.
// - Shadow transfer enable clears itself after its transfer.
module pmt_top (
   input wire logic i_sys_clk,              // Peripheral clock
   input wire logic i_rst_n,                // Asynchronous reset, active low
   input wire logic i_clk_en,               // Freezes all state while low
   input wire pmt_pkg::pmt_bus_t i_bus,     // Register request
   output logic [31:0] o_rdata,             // Read data, cycle after read
   input wire logic [2:0] i_position_input, // Per-channel position inputs
   input wire logic i_trap_input_n,         // Trap input, active low
   input wire logic i_correct_hall_event,   // Correct hall event pulse
   output logic [5:0] o_pwm,                // Main outputs, two per channel, active state chosen per bit by out_sel
   output logic o_second_pwm_pin            // Second timer output pin
);
   import pmt_pkg::*;

   pmt_state_t st_reg;
   pmt_state_t st_next;
   logic m_pm, m_om, m_zm_up, m_end, sc_pm, sc_zm, sc_cm;
   logic [2:0] m_cm;
   logic trig_hit, dir_ok, sw_ev, sync_ev, trap_in, trap_sw_set, trap_sw_clr, trap_exit_ev, trap_now;
   logic main_xfer, sec_xfer, req_set, pat_xfer, mod13;

   function automatic logic wr_at(input pmt_bus_t b, input logic [7:0] off);
      return b.wr && (b.addr == off);
   endfunction

   function automatic logic [31:0] rd_word(input pmt_state_t s, input logic [7:0] a);
      logic [31:0] w;
      w = `PMT_RST_WORD;
      unique case (a)
         `PMT_OFF_CTRL: begin
            w[`PMT_CTRL_MAIN_RUN] = s.main_run;
            w[`PMT_CTRL_MAIN_SS] = s.main_ss;
            w[`PMT_CTRL_MAIN_CENTER] = s.main_center;
            w[`PMT_CTRL_MAIN_STE] = s.main_ste;
            w[`PMT_CTRL_SEC_RUN] = s.sec_run;
            w[`PMT_CTRL_SEC_SS] = s.sec_ss;
            w[`PMT_CTRL_SEC_STE] = s.sec_ste;
            w[`PMT_CTRL_TRIG_EV +: 3] = s.trig_ev;
            w[`PMT_CTRL_TRIG_DIR +: 2] = s.trig_dir;
         end
         `PMT_OFF_MAIN_PER: w[15:0] = s.main_per;
         `PMT_OFF_MAIN_CMP0: w[15:0] = s.main_cmp[0];
         `PMT_OFF_MAIN_CMP0 + 8'h01: w[15:0] = s.main_cmp[1];
         `PMT_OFF_MAIN_CMP0 + 8'h02: w[15:0] = s.main_cmp[2];
         `PMT_OFF_SEC_PER: w[15:0] = s.sec_per;
         `PMT_OFF_SEC_CMP_SH: w[15:0] = s.sec_cmp_sh;
         `PMT_OFF_SEC_CMP: w[15:0] = s.sec_cmp;
         `PMT_OFF_CHAN: begin
            w[`PMT_CHAN_MODE +: 12] = s.ch_mode;
            w[`PMT_CHAN_OUT_SEL +: 6] = s.out_sel;
         end
         `PMT_OFF_MOD: begin
            w[`PMT_MOD_MAIN_EN +: 6] = s.main_en;
            w[`PMT_MOD_SEC_EN +: 6] = s.sec_en;
            w[`PMT_MOD_PSL +: 6] = s.passive_level_field;
         end
         `PMT_OFF_SEC_OUT: begin
            w[`PMT_SOUT_PS] = s.sec_ps;
            w[`PMT_SOUT_IM] = s.sec_im;
            w[`PMT_SOUT_PSL] = s.sec_psl;
            w[`PMT_SOUT_OE] = s.sec_oe;
         end
         `PMT_OFF_PATTERN: begin
            w[`PMT_PAT_SHADOW +: 6] = s.pat_sh;
            w[`PMT_PAT_ACTIVE +: 6] = s.pat;
            w[`PMT_PAT_REM] = s.rem;
            w[`PMT_PAT_SW_SEL +: 3] = s.sw_sel;
            w[`PMT_PAT_SW_SYN +: 2] = s.sw_syn;
            w[`PMT_PAT_EN] = s.pat_en;
         end
         `PMT_OFF_TRAP: begin
            w[`PMT_TRAP_PEN] = s.trap_pen;
            w[`PMT_TRAP_M2] = s.trap_m2;
            w[`PMT_TRAP_SYNC +: 2] = s.trap_sync;
            w[`PMT_TRAP_OE +: 7] = s.trap_oe;
            w[`PMT_TRAP_FLAG] = s.trap_flag;
            w[`PMT_TRAP_STATE] = s.trap_state;
         end
         `PMT_OFF_STATUS: w[3:0] = {s.sec_state, s.ch_state};
         `PMT_OFF_COUNT: w = {s.sec_cnt, s.main_cnt};
         default: w = `PMT_RST_WORD;
      endcase
      return w;
   endfunction

   // Timer events, all qualified by the run bits
   always_comb begin
      m_pm = st_reg.main_run && !st_reg.main_dn && (st_reg.main_cnt == st_reg.main_per);
      m_om = st_reg.main_run && st_reg.main_center && st_reg.main_dn && (st_reg.main_cnt == 16'h0001);
      m_zm_up = st_reg.main_run && !st_reg.main_dn && (st_reg.main_cnt == 16'h0000);
      m_end = st_reg.main_center ? m_om : m_pm;
      for (int i = 0; i < 3; i++) begin
         m_cm[i] = st_reg.main_run && (st_reg.main_cnt == st_reg.main_cmp[i]);
      end
      sc_pm = st_reg.sec_run && (st_reg.sec_cnt == st_reg.sec_per);
      sc_zm = st_reg.sec_run && (st_reg.sec_cnt == 16'h0000);
      sc_cm = st_reg.sec_run && (st_reg.sec_cnt == st_reg.sec_cmp);
      unique case (st_reg.trig_dir)
         `PMT_DIR_UP: dir_ok = !st_reg.main_dn;
         `PMT_DIR_DOWN: dir_ok = st_reg.main_dn;
         `PMT_DIR_ANY: dir_ok = 1'h1;
         default: dir_ok = 1'h0;
      endcase
      unique case (st_reg.trig_ev)
         3'h0, 3'h1, 3'h2: trig_hit = m_cm[st_reg.trig_ev[1:0]];
         `PMT_TRIG_PM: trig_hit = m_pm;
         `PMT_TRIG_ZM: trig_hit = st_reg.main_run && (st_reg.main_cnt == 16'h0000);
         `PMT_TRIG_OM: trig_hit = m_om;
         default: trig_hit = 1'h0;
      endcase
      trig_hit = trig_hit && dir_ok;
      unique case (st_reg.sw_sel)
         `PMT_SW_MAIN_PM: sw_ev = m_pm;
         `PMT_SW_MAIN_OM: sw_ev = m_om;
         `PMT_SW_SEC_PM: sw_ev = sc_pm;
         `PMT_SW_CH1_CM: sw_ev = m_cm[1];
         `PMT_SW_HALL: sw_ev = i_correct_hall_event;
         default: sw_ev = 1'h0;
      endcase
      unique case (st_reg.sw_syn)
         `PMT_SYN_MAIN_ZM: sync_ev = m_zm_up;
         `PMT_SYN_SEC_ZM: sync_ev = sc_zm;
         default: sync_ev = 1'h0;
      endcase
      unique case (st_reg.trap_sync)
         `PMT_TSYN_MAIN: trap_exit_ev = m_end;
         `PMT_TSYN_SEC: trap_exit_ev = sc_pm;
         default: trap_exit_ev = 1'h1;
      endcase
      trap_in = st_reg.trap_pen && !i_trap_input_n;
      trap_sw_set = wr_at(i_bus, `PMT_OFF_TRAP) && i_bus.wdata[`PMT_TRAP_FLAG];
      trap_sw_clr = wr_at(i_bus, `PMT_OFF_TRAP) && !i_bus.wdata[`PMT_TRAP_FLAG];
      trap_now = st_reg.trap_state || trap_in || trap_sw_set;
      main_xfer = st_reg.main_ste && (!st_reg.main_run || m_end || (st_reg.main_center && m_pm));
      sec_xfer = st_reg.sec_ste && (!st_reg.sec_run || sc_pm);
      req_set = sw_ev || (wr_at(i_bus, `PMT_OFF_PATTERN) && i_bus.wdata[`PMT_PAT_REQ]);
      pat_xfer = (st_reg.sw_syn == `PMT_SYN_DIRECT) ? (st_reg.rem || req_set) : (st_reg.rem && sync_ev);
      mod13 = st_reg.sec_state ^ st_reg.sec_im;
   end

   always_comb begin
      logic set_c, clr_c, act;
      set_c = 1'h0;
      clr_c = 1'h0;
      act = 1'h0;
      st_next = st_reg;
      // Main timer counting, edge- or center-aligned
      if (st_reg.main_run) begin
         if (!st_reg.main_center) begin
            st_next.main_cnt = m_pm ? `PMT_RST_CNT : st_reg.main_cnt + 16'h0001;
         end else if (!st_reg.main_dn) begin
            if (m_pm) begin
               st_next.main_dn = (st_reg.main_per != 16'h0000);
               st_next.main_cnt = (st_reg.main_per != 16'h0000) ? st_reg.main_cnt - 16'h0001 : `PMT_RST_CNT;
            end else begin
               st_next.main_cnt = st_reg.main_cnt + 16'h0001;
            end
         end else if (st_reg.main_cnt <= 16'h0001) begin
            st_next.main_dn = 1'h0;
            st_next.main_cnt = `PMT_RST_CNT;
         end else begin
            st_next.main_cnt = st_reg.main_cnt - 16'h0001;
         end
      end
      for (int i = 0; i < 3; i++) begin
         if (st_reg.main_center) begin
            set_c = m_cm[i] && !st_reg.main_dn;
            clr_c = m_cm[i] && st_reg.main_dn;
         end else begin
            set_c = m_cm[i];
            clr_c = m_pm && !m_cm[i];
         end
         if ((st_reg.ch_mode[i] == `PMT_MODE_HYST) && !i_position_input[i]) begin
            set_c = 1'h0;
            clr_c = 1'h1;
         end
         if (set_c) begin
            st_next.ch_state[i] = 1'h1;
         end else if (clr_c) begin
            st_next.ch_state[i] = 1'h0;
         end
      end
      if (st_reg.main_ss && m_end) begin
         st_next.main_run = 1'h0;
         st_next.ch_state = 3'h0;
         st_next.main_cnt = `PMT_RST_CNT;
         st_next.main_dn = 1'h0;
      end
      if (main_xfer) begin
         st_next.main_per = st_reg.main_per_sh;
         st_next.main_cmp = st_reg.main_cmp_sh;
         st_next.main_ste = 1'h0;
      end
      // Second timer: up-only, one compare channel
      if (st_reg.sec_run) begin
         st_next.sec_cnt = sc_pm ? `PMT_RST_CNT : st_reg.sec_cnt + 16'h0001;
      end
      if (sc_cm) begin
         st_next.sec_state = 1'h1;
      end else if (sc_zm) begin
         st_next.sec_state = 1'h0;
      end
      if (st_reg.sec_ss && sc_pm) begin
         st_next.sec_run = 1'h0;
         st_next.sec_state = 1'h0;
         st_next.sec_cnt = `PMT_RST_CNT;
      end
      if (trig_hit) begin
         st_next.sec_run = 1'h1;
      end
      if (sec_xfer) begin
         st_next.sec_per = st_reg.sec_per_sh;
         st_next.sec_cmp = st_reg.sec_cmp_sh;
         st_next.sec_ps = st_reg.sec_ps_sh;
         st_next.sec_im = st_reg.sec_im_sh;
         st_next.sec_psl = st_reg.sec_psl_sh;
         st_next.sec_ste = 1'h0;
      end
      // Pattern reminder; a new request in the transfer cycle survives
      if (pat_xfer) begin
         st_next.pat = st_reg.pat_sh;
      end
      st_next.rem = (st_reg.sw_syn == `PMT_SYN_DIRECT) ? 1'h0 : ((st_reg.rem && !pat_xfer) || req_set);
      // Trap flag: set wins over both clear paths
      if (trap_in || trap_sw_set) begin
         st_next.trap_flag = 1'h1;
      end else if (st_reg.trap_m2 ? trap_sw_clr : 1'h1) begin
         st_next.trap_flag = 1'h0;
      end
      if (trap_in || trap_sw_set) begin
         st_next.trap_state = 1'h1;
      end else if (!st_reg.trap_flag && trap_exit_ev) begin
         st_next.trap_state = 1'h0;
      end
      // Output modulation, registered before the pins
      for (int x = 0; x < 6; x++) begin
         act = (st_reg.main_en[x] || st_reg.sec_en[x] || st_reg.pat_en)
            && (!st_reg.main_en[x] || (st_reg.ch_state[x / 2] == st_reg.out_sel[x]))
            && (!st_reg.sec_en[x] || mod13)
            && (!st_reg.pat_en || st_reg.pat[x])
            && !(trap_now && st_reg.trap_oe[x])
            && !((st_reg.ch_mode[x / 2] == `PMT_MODE_HYST) && !i_position_input[x / 2]);
         st_next.pwm[x] = st_reg.passive_level_field[x] ^ act;
      end
      act = st_reg.sec_oe && (st_reg.sec_state == st_reg.sec_ps) && !(trap_now && st_reg.trap_oe[6]);
      st_next.pin = st_reg.sec_psl ^ act;
      // Software writes
      if (wr_at(i_bus, `PMT_OFF_CTRL)) begin
         st_next.main_run = i_bus.wdata[`PMT_CTRL_MAIN_RUN];
         st_next.main_ss = i_bus.wdata[`PMT_CTRL_MAIN_SS];
         st_next.main_center = i_bus.wdata[`PMT_CTRL_MAIN_CENTER];
         st_next.main_ste = i_bus.wdata[`PMT_CTRL_MAIN_STE] || st_next.main_ste;
         st_next.sec_run = i_bus.wdata[`PMT_CTRL_SEC_RUN] || trig_hit;
         st_next.sec_ss = i_bus.wdata[`PMT_CTRL_SEC_SS];
         st_next.sec_ste = i_bus.wdata[`PMT_CTRL_SEC_STE] || st_next.sec_ste;
         st_next.trig_ev = i_bus.wdata[`PMT_CTRL_TRIG_EV +: 3];
         st_next.trig_dir = i_bus.wdata[`PMT_CTRL_TRIG_DIR +: 2];
      end
      if (wr_at(i_bus, `PMT_OFF_MAIN_PER)) begin
         st_next.main_per_sh = i_bus.wdata[15:0];
      end
      for (int i = 0; i < 3; i++) begin
         if (wr_at(i_bus, `PMT_OFF_MAIN_CMP0 + 8'(i))) begin
            st_next.main_cmp_sh[i] = i_bus.wdata[15:0];
         end
      end
      if (wr_at(i_bus, `PMT_OFF_SEC_PER)) begin
         st_next.sec_per_sh = i_bus.wdata[15:0];
      end
      if (wr_at(i_bus, `PMT_OFF_SEC_CMP_SH)) begin
         st_next.sec_cmp_sh = i_bus.wdata[15:0];
      end
      if (wr_at(i_bus, `PMT_OFF_CHAN)) begin
         st_next.ch_mode = i_bus.wdata[`PMT_CHAN_MODE +: 12];
         st_next.out_sel = i_bus.wdata[`PMT_CHAN_OUT_SEL +: 6];
      end
      if (wr_at(i_bus, `PMT_OFF_MOD)) begin
         st_next.main_en = i_bus.wdata[`PMT_MOD_MAIN_EN +: 6];
         st_next.sec_en = i_bus.wdata[`PMT_MOD_SEC_EN +: 6];
         st_next.passive_level_field = i_bus.wdata[`PMT_MOD_PSL +: 6];
      end
      if (wr_at(i_bus, `PMT_OFF_SEC_OUT)) begin
         st_next.sec_ps_sh = i_bus.wdata[`PMT_SOUT_PS];
         st_next.sec_im_sh = i_bus.wdata[`PMT_SOUT_IM];
         st_next.sec_psl_sh = i_bus.wdata[`PMT_SOUT_PSL];
         st_next.sec_oe = i_bus.wdata[`PMT_SOUT_OE];
      end
      if (wr_at(i_bus, `PMT_OFF_PATTERN)) begin
         st_next.pat_sh = i_bus.wdata[`PMT_PAT_SHADOW +: 6];
         st_next.sw_sel = i_bus.wdata[`PMT_PAT_SW_SEL +: 3];
         st_next.sw_syn = i_bus.wdata[`PMT_PAT_SW_SYN +: 2];
         st_next.pat_en = i_bus.wdata[`PMT_PAT_EN];
         if (pat_xfer && (st_reg.sw_syn == `PMT_SYN_DIRECT)) begin
            st_next.pat = i_bus.wdata[`PMT_PAT_SHADOW +: 6];
         end
      end
      if (wr_at(i_bus, `PMT_OFF_TRAP)) begin
         st_next.trap_pen = i_bus.wdata[`PMT_TRAP_PEN];
         st_next.trap_m2 = i_bus.wdata[`PMT_TRAP_M2];
         st_next.trap_sync = i_bus.wdata[`PMT_TRAP_SYNC +: 2];
         st_next.trap_oe = i_bus.wdata[`PMT_TRAP_OE +: 7];
      end
      st_next.rdata = i_bus.rd ? rd_word(st_reg, i_bus.addr) : `PMT_RST_WORD;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else if (i_clk_en) begin
         st_reg <= st_next;
      end
   end

   assign o_pwm = st_reg.pwm;
   assign o_second_pwm_pin = st_reg.pin;
   assign o_rdata = st_reg.rdata;

   default clocking cb @(posedge i_sys_clk iff i_clk_en);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_main_end_ss;
      st_reg.main_run && st_reg.main_ss && m_end && !wr_at(i_bus, `PMT_OFF_CTRL);
   endsequence
   sequence s_hyst_low0;
      (st_reg.ch_mode[0] == `PMT_MODE_HYST) && !i_position_input[0];
   endsequence
   sequence s_direct_req;
      wr_at(i_bus, `PMT_OFF_PATTERN) && i_bus.wdata[`PMT_PAT_REQ] && (st_reg.sw_syn == `PMT_SYN_DIRECT);
   endsequence

   AST_SINGLE_SHOT_STOP: assert property (s_main_end_ss |=> !st_reg.main_run && (st_reg.ch_state == 3'h0))
      else $error("main timer kept running after single-shot end");
   AST_HYST_CLEAR: assert property (s_hyst_low0 |=> !st_reg.ch_state[0])
      else $error("hysteresis channel state not cleared");
   AST_HYST_PASSIVE: assert property (s_hyst_low0 |=> (o_pwm[1:0] == $past(st_reg.passive_level_field[1:0])))
      else $error("hysteresis channel outputs not passive");
   AST_SECOND_GATE: assert property (!st_reg.sec_run |=> $stable(st_reg.sec_state))
      else $error("second compare state changed while stopped");
   AST_SECOND_SHADOW: assert property (st_reg.sec_ste && sc_pm && !wr_at(i_bus, `PMT_OFF_CTRL)
      |=> (st_reg.sec_cmp == $past(st_reg.sec_cmp_sh)) && !st_reg.sec_ste)
      else $error("second shadow transfer missing");
   AST_START_TRIGGER: assert property (trig_hit |=> st_reg.sec_run)
      else $error("second timer not started by trigger");
   AST_PATTERN_MASK: assert property (st_reg.pat_en && !st_reg.pat[0] |=> o_pwm[0] == $past(st_reg.passive_level_field[0]))
      else $error("masked output became active");
   AST_PATTERN_DIRECT: assert property (s_direct_req
      |=> (st_reg.pat == $past(i_bus.wdata[5:0])) && !st_reg.rem)
      else $error("direct pattern transfer missing");
   AST_TRAP_ENTER: assert property (trap_in |=> st_reg.trap_state && st_reg.trap_flag ##1 st_reg.trap_state)
      else $error("trap state not entered");
   AST_TRAP_HOLD: assert property (st_reg.trap_state && st_reg.trap_flag |=> st_reg.trap_state)
      else $error("trap state left while flag set");
endmodule
`default_nettype wire

// ==== sim/pmt_inverter.sv ====
`timescale 1ns/100ps
`default_nettype none
// Comparator and trip stage of the inverter, answering one clock after each command
module pmt_inverter (
   input wire logic i_sys_clk,           // Peripheral clock
   input wire logic i_rst_n,             // Reset, active low
   input wire logic i_fault,             // Bench asks for an over-current trip
   input wire logic [2:0] i_pos,         // Comparator levels asked for
   output logic o_trap_input_n,          // Trip line, active low
   output logic [2:0] o_position_input   // Comparator outputs
);
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_trap_input_n <= 1'b1;
         o_position_input <= 3'h0;
      end else begin
         o_trap_input_n <= ~i_fault;
         o_position_input <= i_pos;
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pmt_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0, hall = 1'b0, trap_n, pin;
   logic [2:0] pos = 3'h0, pos_w;
   logic [5:0] pwm;
   logic [31:0] rdata, v, passive_level_field, pat, c;
   pmt_bus_t bus = '0;
   int n_errors = 0, n_compared = 0;
   always #10 clk = ~clk;
   pmt_inverter u_pmt_inverter (.i_sys_clk(clk), .i_rst_n(rst_n), .i_fault(fault), .i_pos(pos),
      .o_trap_input_n(trap_n), .o_position_input(pos_w));
   pmt_top u_pmt_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_bus(bus), .o_rdata(rdata),
      .i_position_input(pos_w), .i_trap_input_n(trap_n), .i_correct_hall_event(hall),
      .o_pwm(pwm), .o_second_pwm_pin(pin));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Polls one register bit with a bounded count
   task automatic await(input logic [7:0] a, input int b, input logic val);
      for (int i = 0; i < 50; i++) begin
         rd(a, v);
         if (v[b] === val) return;
      end
      chk(v[b], val);
      complete_run();
   endtask
   initial begin
      void'($urandom(32'h33c1));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, v);
      chk(v, 32'h0000_0000);
      passive_level_field = 32'($urandom) & 32'h0000_003F;
      wr(8'h09, passive_level_field << 16);
      repeat (2) @(posedge clk);
      chk({26'h0, pwm}, passive_level_field);
      $display("test passive done");
      pat = 32'($urandom) & 32'h0000_003F;
      wr(8'h0B, 32'h0101_0000 | pat);
      rd(8'h0B, v);
      chk(v, 32'h0100_0000 | pat << 8 | pat);
      wr(8'h0B, 32'h01D4_0000 | ~pat & 32'h0000_003F);
      @(posedge clk) hall <= 1'b1;
      @(posedge clk) hall <= 1'b0;
      rd(8'h0B, v);
      chk(v, 32'h01D6_0000 | pat << 8 | ~pat & 32'h0000_003F);
      wr(8'h0B, 32'h01C1_0000 | ~pat & 32'h0000_003F);
      rd(8'h0B, v);
      chk(v, 32'h01C2_0000 | pat << 8 | ~pat & 32'h0000_003F);
      wr(8'h0B, 32'h0100_0000 | ~pat & 32'h0000_003F);
      rd(8'h0B, v);
      chk(v[17:8], {2'b00, ~pat[5:0]});
      $display("test pattern done");
      wr(8'h0C, 32'h0001_07F2);
      rd(8'h0C, v);
      chk(v, 32'h0003_07F2);
      chk({26'h0, pwm}, passive_level_field);
      wr(8'h0C, 32'h0000_07F2);
      await(8'h0C, 17, 1'b0);
      chk(v, 32'h0000_07F2);
      wr(8'h0C, 32'h0000_07F1);
      @(posedge clk);
      fault <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h0C, v);
      chk(v, 32'h0003_07F1);
      fault <= 1'b0;
      await(8'h0C, 17, 1'b0);
      chk(v, 32'h0000_07F1);
      $display("test trap done");
      wr(8'h08, 32'h0000_0999);
      wr(8'h01, 32'h0000_0008);
      wr(8'h00, 32'h0000_0009);
      repeat (20) begin
         rd(8'h0D, v);
         chk(v[2:0], 3'h0);
      end
      chk({26'h0, pwm}, passive_level_field);
      pos <= 3'h7;
      await(8'h0D, 0, 1'b1);
      wr(8'h00, 32'h0000_0003);
      await(8'h00, 0, 1'b0);
      rd(8'h0D, v);
      chk(v[2:0], 3'h0);
      $display("test hysteresis done");
      c = 32'($urandom) & 32'h0000_FFFF;
      wr(8'h00, 32'h0000_0000);
      wr(8'h06, c);
      wr(8'h07, ~c);
      wr(8'h0A, 32'h0000_000F);
      rd(8'h07, v);
      chk(v, 32'h0000_0000);
      rd(8'h0A, v);
      chk(v, 32'h0000_0008);
      wr(8'h00, 32'h0000_0050);
      await(8'h00, 6, 1'b0);
      rd(8'h07, v);
      chk(v, c);
      rd(8'h06, v);
      chk(v, c);
      rd(8'h0A, v);
      chk(v, 32'h0000_000F);
      chk(pin, c != 32'h0000_0000);
      $display("test second timer done");
      complete_run();
   end
endmodule
`default_nettype wire
